// File: shared/dps_params.svh
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH

// Clock period and soft-start step spacing
`define DPS_CLK_PERIOD_NS   20
`define DPS_STEP_TIME_US    10
`define DPS_STEP_CYCLES     ((`DPS_STEP_TIME_US * 1000) / `DPS_CLK_PERIOD_NS)
`define DPS_CNT_W           16

// Control byte field positions
`define DPS_CTRL_SOFT_START_BIT_BIT 0

// Reset values
`define DPS_SOFT_START_BIT_RST      1'b0

`endif

// File: shared/dps_pkg.sv
package dps_pkg;

    // Supply and fault conditions from the analog front end
    typedef struct packed {
        logic supplyAbove83;
        logic supplyAbove81;
        logic xrayTrigger;
        logic xraySelHigh;
        logic loopPinGrounded;
    } dps_fault_type;

    // Control-register write from the serial-bus slave
    typedef struct packed {
        logic       wrValid;
        logic       softStartWr;
        logic       softStartVal;
    } dps_ctrl_type;

    // Gated output enables
    typedef struct packed {
        logic horizDriveEn;
        logic bplusDriveEn;
        logic vertOutAEn;
        logic vertOutBEn;
        logic syncUnlockEn;
        logic clampBlankForce;
        logic loopDischarge;
    } dps_outs_type;

    // Soft-start sequence states, one-hot
    typedef enum logic [5:0] {
        DPS_ST_STANDBY = 6'h01,
        DPS_ST_VERT    = 6'h02,
        DPS_ST_HORIZ   = 6'h04,
        DPS_ST_BPLUS   = 6'h08,
        DPS_ST_RUN     = 6'h10,
        DPS_ST_PROT    = 6'h20
    } dps_state_type;

endpackage

// File: hdl/dps_protect_latch.sv
`timescale 1ns/1ps
module dps_protect_latch (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire dps_pkg::dps_fault_type faults,
    input  wire logic                  running,
    output logic                       softCause,
    output logic                       xrayHold
);
    import dps_pkg::*;

    logic xrayHold_r;
    logic xrayHold_nxt;

    // Resistor-selected x-ray latch holds until supply drops out
    always_comb begin
        xrayHold_nxt = xrayHold_r;
        if (!faults.supplyAbove83 && !faults.supplyAbove81) begin
            xrayHold_nxt = 1'b0;
        end
        if (faults.xrayTrigger && faults.xraySelHigh) begin
            xrayHold_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            xrayHold_r <= 1'b0;
        end else begin
            xrayHold_r <= xrayHold_nxt;
        end
    end

    // Causes that clear the soft-start bit
    assign softCause = faults.xrayTrigger || xrayHold_r || (running && !faults.supplyAbove81);
    assign xrayHold  = xrayHold_r;
endmodule

// File: hdl/dps_step_timer.sv
`timescale 1ns/1ps
`include "dps_params.svh"
module dps_step_timer (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic restart,
    output logic      stepDone
);
    logic [`DPS_CNT_W-1:0] cnt_r;
    logic [`DPS_CNT_W-1:0] cnt_nxt;

    // Counts one soft-start step interval
    always_comb begin
        if (restart) begin
            cnt_nxt = '0;
        end else if (cnt_r != `DPS_CNT_W'(`DPS_STEP_CYCLES - 1)) begin
            cnt_nxt = cnt_r + `DPS_CNT_W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Compare on the count only, so the sequencer's next state never loops back through restart
    assign stepDone = (cnt_r == `DPS_CNT_W'(`DPS_STEP_CYCLES - 1));
endmodule

// File: hdl/deflection_protection_sequencer.sv
`timescale 1ns/1ps
`include "dps_params.svh"
module deflection_protection_sequencer (
    input  wire logic                   ref_clk,
    input  wire logic                   srst,
    input  wire dps_pkg::dps_fault_type faults,
    input  wire dps_pkg::dps_ctrl_type  ctrl,
    output logic                        busAck,
    output logic                        regLoadEn,
    output logic                        soft_start_bit,
    output dps_pkg::dps_outs_type       outs,
    output dps_pkg::dps_state_type      seqState
);
    import dps_pkg::*;

    logic          softStart_r;
    logic          softStart_nxt;
    logic          dataSeen_r;
    logic          dataSeen_nxt;
    dps_state_type state_r;
    dps_state_type state_nxt;
    dps_outs_type  outs_r;
    dps_outs_type  outs_nxt;
    logic          softCause;
    logic          xrayHold;
    logic          stepDone;
    logic          restart;
    logic          supplyOk;
    logic          running;

    assign supplyOk = faults.supplyAbove83;
    assign running  = (state_r != DPS_ST_STANDBY) && (state_r != DPS_ST_PROT);

    dps_protect_latch uLatch (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .faults    (faults),
        .running   (running),
        .softCause (softCause),
        .xrayHold  (xrayHold)
    );

    assign restart = (state_nxt != state_r);

    dps_step_timer uTimer (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .restart  (restart),
        .stepDone (stepDone)
    );

    // Acknowledge and register loading only with adequate supply
    assign busAck    = ctrl.wrValid && supplyOk;
    assign regLoadEn = supplyOk;

    // Soft-start bit and first-data flag
    always_comb begin
        softStart_nxt = softStart_r;
        dataSeen_nxt  = dataSeen_r;
        if (busAck) begin
            dataSeen_nxt = 1'b1;
        end
        if (ctrl.wrValid && ctrl.softStartWr && supplyOk) begin
            softStart_nxt = ctrl.softStartVal;
        end
        if (softCause) begin
            softStart_nxt = 1'b0;
        end
        if (!supplyOk && !(running && faults.supplyAbove81)) begin
            softStart_nxt = 1'b0;
        end
        if (!faults.supplyAbove81) begin
            dataSeen_nxt  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            softStart_r <= `DPS_SOFT_START_BIT_RST;
            dataSeen_r  <= 1'b0;
        end else begin
            softStart_r <= softStart_nxt;
            dataSeen_r  <= dataSeen_nxt;
        end
    end

    // Sequencer: standby, ordered release, run, protection
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DPS_ST_STANDBY: begin
                if (softStart_r && dataSeen_r && supplyOk && !faults.loopPinGrounded) begin
                    state_nxt = DPS_ST_VERT;
                end
            end
            DPS_ST_VERT: begin
                if (stepDone) begin
                    state_nxt = DPS_ST_HORIZ;
                end
            end
            DPS_ST_HORIZ: begin
                if (stepDone) begin
                    state_nxt = DPS_ST_BPLUS;
                end
            end
            DPS_ST_BPLUS: begin
                if (stepDone) begin
                    state_nxt = DPS_ST_RUN;
                end
            end
            DPS_ST_RUN: begin
            end
            DPS_ST_PROT: begin
                // Protection holds until a fresh soft start, or until the loop pin alone is released
                if (softStart_r && dataSeen_r && !faults.loopPinGrounded && !softCause && supplyOk) begin
                    state_nxt = DPS_ST_VERT;
                end
            end
            default: begin
                state_nxt = DPS_ST_PROT;
            end
        endcase
        if (running && (softCause || faults.loopPinGrounded || !softStart_r)) begin
            state_nxt = DPS_ST_PROT;
        end
    end

    // Output enables follow the sequence state
    always_comb begin
        outs_nxt = '0;
        unique case (state_nxt)
            DPS_ST_VERT: begin
                outs_nxt.vertOutAEn = 1'b1;
                outs_nxt.vertOutBEn = 1'b1;
            end
            DPS_ST_HORIZ: begin
                outs_nxt.vertOutAEn   = 1'b1;
                outs_nxt.vertOutBEn   = 1'b1;
                outs_nxt.horizDriveEn = 1'b1;
            end
            DPS_ST_BPLUS: begin
                outs_nxt.vertOutAEn   = 1'b1;
                outs_nxt.vertOutBEn   = 1'b1;
                outs_nxt.horizDriveEn = 1'b1;
                outs_nxt.bplusDriveEn = 1'b1;
            end
            DPS_ST_RUN: begin
                outs_nxt.vertOutAEn   = 1'b1;
                outs_nxt.vertOutBEn   = 1'b1;
                outs_nxt.horizDriveEn = 1'b1;
                outs_nxt.bplusDriveEn = 1'b1;
                outs_nxt.syncUnlockEn = 1'b1;
            end
            DPS_ST_PROT: begin
                outs_nxt.clampBlankForce = 1'b1;
                outs_nxt.loopDischarge   = 1'b1;
            end
            default: begin
                outs_nxt.clampBlankForce = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= DPS_ST_STANDBY;
            outs_r  <= '0;
        end else begin
            state_r <= state_nxt;
            outs_r  <= outs_nxt;
        end
    end

    assign soft_start_bit = softStart_r;
    assign outs           = outs_r;
    assign seqState       = state_r;

    // Helper for output-gating checks
    logic anyDrive;
    assign anyDrive = outs_r.horizDriveEn | outs_r.bplusDriveEn | outs_r.vertOutAEn
                    | outs_r.vertOutBEn | outs_r.syncUnlockEn;

    sequence lowSupply_s;
        !faults.supplyAbove83 && !running;
    endsequence

    noack_low_a: assert property (@(posedge ref_clk) disable iff (srst)
        !faults.supplyAbove83 |-> !busAck) else $error("ack given at low supply");
    ack_ok_a: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl.wrValid && faults.supplyAbove83 |-> busAck) else $error("write not acked");
    gate_off_a: assert property (@(posedge ref_clk) disable iff (srst)
        lowSupply_s ##1 1'b1 |-> !anyDrive) else $error("outputs active at low supply");
    soft_start_bit_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl.wrValid && ctrl.softStartWr && ctrl.softStartVal && supplyOk && !softCause
        |=> soft_start_bit) else $error("soft start not set");
    order_hb_a: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(outs_r.bplusDriveEn) |-> $past(outs_r.horizDriveEn)) else $error("B+ before horizontal");
    dip_prot_a: assert property (@(posedge ref_clk) disable iff (srst)
        running && !faults.supplyAbove81 |=> state_r == DPS_ST_PROT && !outs_r.syncUnlockEn)
        else $error("dip missed");
    xray_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
        faults.xrayTrigger |=> !soft_start_bit) else $error("soft start survived xray");
    prot_float_a: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == DPS_ST_PROT |-> !anyDrive && outs_r.clampBlankForce && outs_r.loopDischarge)
        else $error("protection outputs wrong");
    loop_prot_a: assert property (@(posedge ref_clk) disable iff (srst)
        running && faults.loopPinGrounded |=> state_r == DPS_ST_PROT) else $error("loop pin ignored");
    xlatch_a: assert property (@(posedge ref_clk) disable iff (srst)
        xrayHold && faults.supplyAbove81 |=> xrayHold && !soft_start_bit) else $error("latch lost");

    // Cycles spent in the current sequence state, for step-spacing checks
    logic [`DPS_CNT_W-1:0] stateAge_r;
    logic [`DPS_CNT_W-1:0] stateAge_nxt;

    // Restarts on every state change, saturates at all ones
    always_comb begin
        if (state_nxt != state_r) begin
            stateAge_nxt = '0;
        end else if (stateAge_r != '1) begin
            stateAge_nxt = stateAge_r + `DPS_CNT_W'(1);
        end else begin
            stateAge_nxt = stateAge_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stateAge_r <= '0;
        end else begin
            stateAge_r <= stateAge_nxt;
        end
    end

    // One of the timed release steps
    sequence stepState_s;
        (state_r == DPS_ST_VERT) || (state_r == DPS_ST_HORIZ) || (state_r == DPS_ST_BPLUS);
    endsequence

    // A timed step moving on to the next, not aborted into protection
    sequence stepAdvance_s;
        stepState_s ##0 (state_nxt != state_r) && (state_nxt != DPS_ST_PROT);
    endsequence

    // Standby left for the first release step
    sequence releaseStart_s;
        (state_r == DPS_ST_STANDBY) ##1 (state_r == DPS_ST_VERT);
    endsequence

    // Grounded loop pin let go while nothing else holds protection
    sequence loopRelease_s;
        (state_r == DPS_ST_PROT) && faults.loopPinGrounded
        ##1 !faults.loopPinGrounded && !softCause && soft_start_bit && dataSeen_r && supplyOk;
    endsequence

    // Release order and spacing
    step_gap_a: assert property (@(posedge ref_clk) disable iff (srst)
        stepAdvance_s |-> stateAge_r == `DPS_CNT_W'(`DPS_STEP_CYCLES - 1))
        else $error("step spacing wrong");
    order_vh_a: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(outs_r.horizDriveEn) |-> $past(outs_r.vertOutAEn) && $past(outs_r.vertOutBEn))
        else $error("horizontal before vertical");
    order_bu_a: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(outs_r.syncUnlockEn) |-> $past(outs_r.bplusDriveEn))
        else $error("unlock before B+");
    release_vert_a: assert property (@(posedge ref_clk) disable iff (srst)
        releaseStart_s |-> outs_r.vertOutAEn && outs_r.vertOutBEn
        && !outs_r.horizDriveEn && !outs_r.bplusDriveEn) else $error("first release step wrong");

    // Gating before any data and at low supply
    nodata_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
        !dataSeen_r && (state_r == DPS_ST_STANDBY) |=> !anyDrive)
        else $error("outputs active without data");
    standby_blank_a: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == DPS_ST_STANDBY) && !$past(srst) |-> outs_r.clampBlankForce && !anyDrive)
        else $error("standby outputs wrong");
    low_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        !faults.supplyAbove83 && !running |=> !soft_start_bit)
        else $error("soft start kept at low supply");

    // Protection causes and their exits
    dip_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        running && !faults.supplyAbove81 |=> !soft_start_bit)
        else $error("soft start survived dip");
    prot_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == DPS_ST_PROT) && !soft_start_bit |=> state_r == DPS_ST_PROT)
        else $error("protection left without soft start");
    loop_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
        faults.loopPinGrounded && !softCause && !ctrl.wrValid && soft_start_bit && supplyOk
        |=> soft_start_bit) else $error("loop pin cleared soft start");
    loop_exit_a: assert property (@(posedge ref_clk) disable iff (srst)
        loopRelease_s |=> state_r == DPS_ST_VERT)
        else $error("loop release did not resume");
    xlatch_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
        !faults.supplyAbove83 && !faults.supplyAbove81 && !faults.xrayTrigger |=> !xrayHold)
        else $error("latch survived supply cycle");
    discharge_only_a: assert property (@(posedge ref_clk) disable iff (srst)
        outs_r.loopDischarge |-> state_r == DPS_ST_PROT)
        else $error("discharge outside protection");
endmodule

// File: dv/dps_host_model.sv
`timescale 1ns/1ps
module dps_host_model (
    input  wire logic            ref_clk,
    input  wire logic            busAck,
    output dps_pkg::dps_ctrl_type ctrl
);
    import dps_pkg::*;

    logic ackSeen;

    initial begin
        ctrl = '0;
        ackSeen = 1'b0;
    end

    // One serial write, held for the single edge that takes it
    task automatic write_byte(input logic touchSoft, input logic val);
        @(posedge ref_clk);
        #1;
        ctrl = '{wrValid: 1'b1, softStartWr: touchSoft, softStartVal: val};
        @(posedge ref_clk);
        ackSeen = busAck; // Answer taken at the edge that takes the write
        #1;
        ctrl = '0;
    endtask

    // Leaving protection: reload registers first, then set the soft-start bit
    task automatic restart_seq();
        write_byte(1'b0, 1'b0);
        write_byte(1'b0, 1'b0);
        write_byte(1'b1, 1'b1);
    endtask
endmodule

// File: dv/deflection_protection_sequencer_tb.sv
`timescale 1ns/1ps
module deflection_protection_sequencer_tb;
    import dps_pkg::*;

    logic          ref_clk;
    logic          srst;
    dps_fault_type faults;
    dps_ctrl_type  ctrl;
    logic          busAck;
    logic          regLoadEn;
    logic          soft_start_bit;
    dps_outs_type  outs;
    dps_state_type seqState;
    int            fails;
    int            checkCount;
    int            cycles;
    dps_state_type stepSt [4] = '{DPS_ST_VERT, DPS_ST_HORIZ, DPS_ST_BPLUS, DPS_ST_RUN};
    logic [4:0]    stepEn [4] = '{5'h06, 5'h16, 5'h1E, 5'h1F};

    deflection_protection_sequencer dut (
        .ref_clk        (ref_clk),
        .srst           (srst),
        .faults         (faults),
        .ctrl           (ctrl),
        .busAck         (busAck),
        .regLoadEn      (regLoadEn),
        .soft_start_bit (soft_start_bit),
        .outs           (outs),
        .seqState       (seqState)
    );

    dps_host_model host (
        .ref_clk (ref_clk),
        .busAck  (busAck),
        .ctrl    (ctrl)
    );

    // Free-running 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    // Inputs change one nanosecond after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_state(input dps_state_type exp, input int lim);
        int n;
        n = 0;
        while (seqState !== exp && n < lim) begin
            tick(1);
            n++;
        end
        chk(seqState, exp);
    endtask

    // Low supply: standby, no acknowledge, bit held clear, no data yet
    task automatic t_low();
        chk(outs[6:2], 5'h00);
        chk(seqState, DPS_ST_STANDBY);
        host.write_byte(1'b1, 1'b1);
        chk(host.ackSeen, 1'b0);
        chk(soft_start_bit, 1'b0);
        chk(regLoadEn, 1'b0);
        faults.supplyAbove83 = 1'b1;
        faults.supplyAbove81 = 1'b1;
        tick(20);
        chk(regLoadEn, 1'b1);
        chk(outs[6:2], 5'h00);
        chk(seqState, DPS_ST_STANDBY);
    endtask

    // Soft start: outputs released stage by stage, exactly 500 cycles apart
    task automatic t_start();
        host.write_byte(1'b1, 1'b1);
        chk(host.ackSeen, 1'b1);
        chk(soft_start_bit, 1'b1);
        wait_state(DPS_ST_VERT, 4);
        for (int i = 0; i < 4; i++) begin
            chk(seqState, stepSt[i]);
            chk(outs[6:2], stepEn[i]);
            if (i < 3) begin
                tick(499);
                chk(seqState, stepSt[i]);
                tick(1);
                chk(seqState, stepSt[i + 1]);
            end
        end
    endtask

    // Common look of protection mode
    task automatic chk_prot();
        chk(outs, 7'h03);
        chk(soft_start_bit, 1'b0);
    endtask

    // Supply dip from run, then reload and soft start
    task automatic t_dip();
        faults.supplyAbove83 = 1'b0;
        faults.supplyAbove81 = 1'b0;
        wait_state(DPS_ST_PROT, 5);
        chk_prot();
        faults.supplyAbove83 = 1'b1;
        faults.supplyAbove81 = 1'b1;
        tick(10);
        chk(outs[6:2], 5'h00);
        chk(seqState, DPS_ST_PROT);
        host.restart_seq();
        wait_state(DPS_ST_VERT, 5);
    endtask

    // X-ray with select low or high
    task automatic t_xray(input logic selHigh);
        faults.xraySelHigh = selHigh;
        faults.xrayTrigger = 1'b1;
        wait_state(DPS_ST_PROT, 5);
        chk_prot();
        faults.xrayTrigger = 1'b0;
        tick(20);
        chk(outs[6:2], 5'h00);
        chk(seqState, DPS_ST_PROT);
        if (selHigh) begin
            host.restart_seq();
            tick(5);
            chk(seqState, DPS_ST_PROT);
            faults.supplyAbove83 = 1'b0;
            faults.supplyAbove81 = 1'b0;
            tick(5);
            faults.supplyAbove83 = 1'b1;
            faults.supplyAbove81 = 1'b1;
            tick(2);
        end
        host.restart_seq();
        wait_state(DPS_ST_VERT, 5);
        faults.xraySelHigh = 1'b0;
    endtask

    // Grounded loop pin: protection without clearing the bit
    task automatic t_loop();
        faults.loopPinGrounded = 1'b1;
        wait_state(DPS_ST_PROT, 5);
        chk(outs, 7'h03);
        chk(soft_start_bit, 1'b1);
        faults.loopPinGrounded = 1'b0;
        wait_state(DPS_ST_VERT, 10);
    endtask

    initial begin
        ref_clk = 1'b0;
        srst = 1'b1;
        faults = '0;
        fails = 0;
        checkCount = 0;
        cycles = 0;
        tick(20);
        srst = 1'b0;
        tick(1);
        chk(outs.clampBlankForce, 1'b1);
        t_low();
        t_start();
        t_dip();
        t_xray(1'b0);
        t_xray(1'b1);
        t_loop();
        print_verdict();
    end
endmodule
